// >>> rtl/usfr_map.svh
// Purpose: offsets, field positions and reset values of the serial block
// Assumes: word-wide register port with an 8-bit data path
// Notes: included by the design modules and by the checker and testbench files
`ifndef USFR_MAP_SVH
`define USFR_MAP_SVH
// register offsets
`define USFR_DATA_BUFFER_REG 3'h0
`define USFR_STATUS_REG_A 3'h1
`define USFR_CONTROL_REG_B 3'h2
`define USFR_CONTROL_REG_C 3'h3
`define USFR_BAUD_REG 3'h4
// status_reg_a bit positions
`define USFR_A_RX_READY 7
`define USFR_A_TX_DONE 6
`define USFR_A_TX_EMPTY 5
`define USFR_A_FRAMING 4
`define USFR_A_OVERRUN 3
`define USFR_A_PARITY 2
// control_reg_b bit positions
`define USFR_B_TX_DONE_IE 6
`define USFR_B_TX_EMPTY_IE 5
`define USFR_B_RX_EN 4
`define USFR_B_TX_EN 3
`define USFR_B_RX_NINTH 1
`define USFR_B_TX_NINTH 0
// control_reg_c bit positions
`define USFR_C_SYNC 6
`define USFR_C_PAR_EN 5
`define USFR_C_PAR_ODD 4
`define USFR_C_STOP2 3
`define USFR_C_SIZE_HI 2
`define USFR_C_SIZE_LO 0
// reset values
`define USFR_RST_B 8'h00
`define USFR_RST_C 8'h03
`define USFR_RST_BAUD 8'h00
// receive fifo depth
`define USFR_RX_DEPTH 2
`endif

// >>> rtl/usfr_rx_mem.sv
// Purpose: two-entry receive frame store with registered read data
// Assumes: single clock, caller never writes a full store
// Notes: entry holds 9 data bits plus framing and parity status
`timescale 1ns/1ps
`default_nettype none
`include "usfr_map.svh"
module usfr_rx_mem
  import usfr_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic flush,
  input wire logic wr_en,
  input wire usfr_rx_ent_s wr_data,
  input wire logic rd_adv,
  output logic rd_valid,
  output usfr_rx_ent_s rd_data
);
  // storage, pointers and count kept together
  typedef struct packed {
    usfr_rx_ent_s [`USFR_RX_DEPTH-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    usfr_rx_ent_s out;
  } usfr_mem_s;
  usfr_mem_s st_q;
  usfr_mem_s st_d;

  // next state: flush, else pop then push, then refresh the output register
  always_comb
  begin
    st_d = st_q;
    if (flush)
    begin
      st_d.cnt = 2'h0;
      st_d.wp = 1'b0;
      st_d.rp = 1'b0;
    end
    else
    begin
      // pop only when data is there
      if (rd_adv && st_q.cnt != 2'h0)
      begin
        st_d.rp = ~st_q.rp;
        st_d.cnt = st_d.cnt - 2'h1;
      end
      if (wr_en)
      begin
        st_d.mem[st_q.wp] = wr_data;
        st_d.wp = ~st_q.wp;
        st_d.cnt = st_d.cnt + 2'h1;
      end
    end
    // head entry registered so readers see a flop output
    st_d.out = st_d.mem[st_d.rp];
  end

  // state register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rd_valid = (st_q.cnt != 2'h0);
  assign rd_data = st_q.out;
endmodule
`default_nettype wire

// >>> rtl/usfr_pkg.sv
// Purpose: types shared by the serial block modules
// Assumes: constants come from usfr_map.svh
// Notes: no numbers live here besides state codes
package usfr_pkg;
  // transmit sequencer states
  typedef enum logic [2:0] {
    USFR_TX_IDLE = 3'b000,
    USFR_TX_START = 3'b001,
    USFR_TX_DATA = 3'b010,
    USFR_TX_PAR = 3'b011,
    USFR_TX_STOP = 3'b100
  } usfr_tx_e;
  // receive sequencer states
  typedef enum logic [2:0] {
    USFR_RX_IDLE = 3'b000,
    USFR_RX_START = 3'b001,
    USFR_RX_DATA = 3'b010,
    USFR_RX_PAR = 3'b011,
    USFR_RX_STOP = 3'b100
  } usfr_rx_e;
  // one buffered received frame
  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
    logic par_err;
  } usfr_rx_ent_s;
endpackage

// >>> rtl/usfr_core.sv
// What this block does
// R1 - empty flag high while holding buffer empty
// R2 - software writes zero to empty flag
// R3 - empty irq level while flag and enable
// R4 - data buffer write clears empty flag
// R5 - handler refills buffer or drops enable
// R6 - done flag sets after last frame, buffer empty
// R7 - done flag cleared by ack or write-one
// R8 - done irq requested while flag and enable
// R9 - parity bit after data, before stop
// R10 - transmit disable waits for pending frames
// R11 - disabled transmitter releases serial output pin
// R12 - receive enable takes over serial input pin
// R13 - sync mode samples on external clock
// R14 - capture starts at valid start bit
// R15 - second stop bit ignored by receiver
// R16 - first stop bit moves frame to buffer
// R17 - unused upper received bits read zero
// R18 - software reads ninth bit, status first
// R19 - data byte read advances receive fifo
// R20 - ninth bit passed like any data bit
// R21 - software loads tx ninth bit first
// R22 - parity is xor, inverted for odd
// R23 - receive-ready high while buffer unread
// R24 - irqs are levels, global gating outside
//
// Purpose: serial transmitter flags, parity, deferred disable, receiver
// Assumes: mclk 125 MHz; register port read data one cycle after strobe
// Notes: baud tick is a divider of mclk; async receive samples mid-bit
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "usfr_map.svh"
module usfr_core
  import usfr_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic serial_in_pin,
  input wire logic sync_clock_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic serial_in_own,
  output logic tx_empty_irq,
  input wire logic tx_done_irq_ack,
  output logic tx_done_irq
);
  // whole block state
  typedef struct packed {
    logic [7:0] ctl_b;
    logic [7:0] ctl_c;
    logic [7:0] baud;
    logic [7:0] rdata;
    logic [8:0] hold;
    logic hold_full;
    logic tx_done;
    logic tx_on;
    usfr_tx_e tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [7:0] tx_div;
    logic txo;
    logic [1:0] in_sy;
    logic [1:0] ck_sy;
    logic ck_prev;
    usfr_rx_e rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] rx_div;
    logic rx_par;
    logic overrun;
    logic pend;
    usfr_rx_ent_s pend_ent;
    logic [1:0] fill;
  } usfr_core_s;
  usfr_core_s st_q;
  usfr_core_s st_d;

  // fifo hookup
  logic fifo_wr;
  logic fifo_adv;
  logic fifo_valid;
  usfr_rx_ent_s fifo_in;
  usfr_rx_ent_s fifo_out;
  logic rx_flush;

  // data bits per character from the size field
  function automatic logic [3:0] char_bits(input logic [2:0] sz);
    case (sz)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  // parity of the data bits below n
  function automatic logic par_of(input logic [8:0] d, input logic [3:0] n,
    input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
      if (4'(i) < n)
        p = p ^ d[i];
    par_of = p; // R22
  endfunction

  // mask of low n bits, used by tx load and rx readout
  function automatic logic [8:0] keep_low(input logic [8:0] d,
    input logic [3:0] n);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < 9; i++)
      m[i] = (4'(i) < n);
    keep_low = d & m;
  endfunction

  logic [3:0] nbits;
  logic sync_mode;
  logic rx_in;
  logic ck_rise;
  logic ck_fall;
  assign nbits = char_bits(st_q.ctl_c[`USFR_C_SIZE_HI:`USFR_C_SIZE_LO]);
  assign sync_mode = st_q.ctl_c[`USFR_C_SYNC];
  assign rx_in = st_q.in_sy[1];
  assign ck_rise = st_q.ck_sy[1] & ~st_q.ck_prev;
  assign ck_fall = ~st_q.ck_sy[1] & st_q.ck_prev;

  // next-state logic for registers, transmitter and receiver
  always_comb
  begin
    logic tx_tick;
    logic rx_tick;
    logic rx_bit;
    logic was_empty;
    logic [3:0] half;
    logic [8:0] rd_low;
    rd_low = '0;
    tx_tick = 1'b0;
    rx_tick = 1'b0;
    rx_bit = 1'b0;
    was_empty = 1'b0;
    half = 4'h0;
    st_d = st_q;
    fifo_wr = 1'b0;
    fifo_adv = 1'b0;
    fifo_in = '0;
    // pin synchronisers, first stage read only by the second
    st_d.in_sy = {st_q.in_sy[0], serial_in_pin};
    st_d.ck_sy = {st_q.ck_sy[0], sync_clock_pin};
    st_d.ck_prev = st_q.ck_sy[1];

    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `USFR_DATA_BUFFER_REG:
        begin
          // ninth bit taken from control_reg_b now
          st_d.hold = {st_q.ctl_b[`USFR_B_TX_NINTH], reg_wdata};
          st_d.hold_full = 1'b1; // R4 R21
        end
        `USFR_STATUS_REG_A:
          // write-one clears done; other bits ignore writes
          if (reg_wdata[`USFR_A_TX_DONE])
            st_d.tx_done = 1'b0; // R7 R2
        `USFR_CONTROL_REG_B:
          // rx ninth bit is read only
          st_d.ctl_b = reg_wdata & ~(8'h01 << `USFR_B_RX_NINTH);
        `USFR_CONTROL_REG_C:
          st_d.ctl_c = reg_wdata;
        `USFR_BAUD_REG:
          st_d.baud = reg_wdata;
        default: ;
      endcase
    end
    // taken interrupt clears done
    if (tx_done_irq_ack)
      st_d.tx_done = 1'b0; // R7

    // register reads, answered next cycle
    if (reg_rd)
    begin
      case (reg_addr)
        `USFR_DATA_BUFFER_REG:
        begin
          rd_low = keep_low(fifo_out.data, nbits);
          st_d.rdata = rd_low[7:0]; // R17
          fifo_adv = fifo_valid; // R19
        end
        `USFR_STATUS_REG_A:
        begin
          st_d.rdata = '0;
          st_d.rdata[`USFR_A_RX_READY] = fifo_valid; // R23
          st_d.rdata[`USFR_A_TX_DONE] = st_q.tx_done;
          st_d.rdata[`USFR_A_TX_EMPTY] = ~st_q.hold_full; // R1
          st_d.rdata[`USFR_A_FRAMING] = fifo_valid & fifo_out.frame_err;
          st_d.rdata[`USFR_A_OVERRUN] = st_q.overrun;
          st_d.rdata[`USFR_A_PARITY] = fifo_valid & fifo_out.par_err;
        end
        `USFR_CONTROL_REG_B:
        begin
          st_d.rdata = st_q.ctl_b;
          st_d.rdata[`USFR_B_RX_NINTH] = fifo_valid & fifo_out.data[8]; // R20
        end
        `USFR_CONTROL_REG_C: st_d.rdata = st_q.ctl_c;
        `USFR_BAUD_REG: st_d.rdata = st_q.baud;
        default: st_d.rdata = 8'h00;
      endcase
    end

    // transmit bit timing: baud divider or sync clock falling edge
    if (sync_mode)
      tx_tick = ck_fall;
    else if (st_q.tx_div == st_q.baud)
      tx_tick = 1'b1;
    st_d.tx_div = (tx_tick || st_q.tx_st == USFR_TX_IDLE) ? 8'h00
      : st_q.tx_div + 8'h01;

    // transmitter enable, disable deferred until idle and buffer empty
    if (st_q.ctl_b[`USFR_B_TX_EN])
      st_d.tx_on = 1'b1;
    else if (st_q.tx_st == USFR_TX_IDLE && !st_q.hold_full)
      st_d.tx_on = 1'b0; // R10

    // transmit sequencer
    unique case (st_q.tx_st)
      USFR_TX_IDLE:
      begin
        st_d.txo = 1'b1;
        if (st_q.tx_on && st_q.hold_full)
        begin
          st_d.tx_sh = {2'b00, keep_low(st_q.hold, nbits)};
          st_d.tx_sh[9] = par_of(st_q.hold, nbits, st_q.ctl_c[`USFR_C_PAR_ODD]);
          st_d.hold_full = reg_wr && reg_addr == `USFR_DATA_BUFFER_REG; // R1
          st_d.tx_st = USFR_TX_START;
        end
      end
      USFR_TX_START:
      begin
        st_d.txo = 1'b0;
        if (tx_tick)
        begin
          st_d.tx_cnt = 4'h0;
          st_d.tx_st = USFR_TX_DATA;
          st_d.txo = st_q.tx_sh[0];
        end
      end
      USFR_TX_DATA:
        if (tx_tick)
        begin
          st_d.tx_cnt = st_q.tx_cnt + 4'h1;
          if (st_q.tx_cnt + 4'h1 == nbits)
          begin
            // parity slot between last data bit and stop
            if (st_q.ctl_c[`USFR_C_PAR_EN])
            begin
              st_d.tx_st = USFR_TX_PAR; // R9
              st_d.txo = st_q.tx_sh[9];
            end
            else
            begin
              st_d.tx_st = USFR_TX_STOP;
              st_d.txo = 1'b1;
              st_d.tx_cnt = 4'h0;
            end
          end
          else
            st_d.txo = st_q.tx_sh[st_q.tx_cnt + 4'h1];
        end
      USFR_TX_PAR:
        if (tx_tick)
        begin
          st_d.tx_st = USFR_TX_STOP;
          st_d.txo = 1'b1;
          st_d.tx_cnt = 4'h0;
        end
      USFR_TX_STOP:
        if (tx_tick)
        begin
          // stop select in ctl_c bit 3 gives a second stop bit
          if (st_q.tx_cnt == 4'h0 && st_q.ctl_c[`USFR_C_STOP2])
            st_d.tx_cnt = 4'h1;
          else
          begin
            st_d.tx_st = USFR_TX_IDLE;
            was_empty = !st_q.hold_full || !st_q.tx_on;
            if (was_empty)
              st_d.tx_done = 1'b1; // R6
          end
        end
      default: st_d.tx_st = USFR_TX_IDLE;
    endcase

    // receive bit timing: sync clock rise or mid-bit of the divider
    half = 4'h0;
    if (sync_mode)
      rx_tick = ck_rise; // R13
    else if (st_q.rx_div == st_q.baud)
      rx_tick = 1'b1;
    rx_bit = rx_in;

    // move the waiting frame once the store has a free slot
    // placed first so a new stop bit or start bit below wins
    if (st_q.pend && st_q.ctl_b[`USFR_B_RX_EN] &&
      st_q.fill != 2'(`USFR_RX_DEPTH))
    begin
      fifo_wr = 1'b1;
      fifo_in = st_q.pend_ent; // R16
      st_d.pend = 1'b0;
      st_d.overrun = 1'b0;
    end

    // receive sequencer, only while enabled
    if (!st_q.ctl_b[`USFR_B_RX_EN])
    begin
      st_d.rx_st = USFR_RX_IDLE;
      st_d.pend = 1'b0;
      st_d.overrun = 1'b0;
    end
    else
    begin
      st_d.rx_div = rx_tick ? 8'h00 : st_q.rx_div + 8'h01;
      unique case (st_q.rx_st)
        USFR_RX_IDLE:
          // sync: start bit is only seen on a clock rise
          if (!rx_bit && (!sync_mode || rx_tick))
          begin
            // async: check start again two cycles later
            st_d.rx_div = {1'b0, st_q.baud[7:1]};
            st_d.rx_st = sync_mode ? USFR_RX_DATA : USFR_RX_START; // R14
            st_d.rx_cnt = 4'h0;
            st_d.rx_sh = '0;
            if (st_q.pend)
              st_d.overrun = 1'b1;
          end
        USFR_RX_START:
          if (st_q.rx_div == {1'b0, st_q.baud[7:1]} + 8'h01 && rx_bit)
            st_d.rx_st = USFR_RX_IDLE; // R14
          else if (rx_tick)
            st_d.rx_st = USFR_RX_DATA;
        USFR_RX_DATA:
          if (rx_tick)
          begin
            st_d.rx_sh[st_q.rx_cnt] = rx_bit; // R14
            st_d.rx_cnt = st_q.rx_cnt + 4'h1;
            if (st_q.rx_cnt + 4'h1 == nbits)
              st_d.rx_st = st_q.ctl_c[`USFR_C_PAR_EN] ? USFR_RX_PAR
                : USFR_RX_STOP;
          end
        USFR_RX_PAR:
          if (rx_tick)
          begin
            st_d.rx_par = rx_bit;
            st_d.rx_st = USFR_RX_STOP;
          end
        USFR_RX_STOP:
          if (rx_tick)
          begin
            // first stop bit ends the frame; a second is never awaited
            st_d.pend_ent.data = st_q.rx_sh; // R15 R20
            st_d.pend_ent.frame_err = ~rx_bit;
            st_d.pend_ent.par_err = st_q.ctl_c[`USFR_C_PAR_EN] &&
              (st_q.rx_par != par_of(st_q.rx_sh, nbits,
              st_q.ctl_c[`USFR_C_PAR_ODD]));
            st_d.rx_st = USFR_RX_IDLE;
            st_d.pend = 1'b1;
          end
        default: st_d.rx_st = USFR_RX_IDLE;
      endcase
    end
    // store fill level, cleared together with the flush
    if (!st_q.ctl_b[`USFR_B_RX_EN])
      st_d.fill = 2'h0;
    else
      st_d.fill = st_q.fill + {1'b0, fifo_wr} - {1'b0, fifo_adv};
  end

  // receive store, emptied while the receiver is off
  assign rx_flush = ~st_q.ctl_b[`USFR_B_RX_EN];
  usfr_rx_mem rx_mem_u (
    .mclk(mclk),
    .resetn(resetn),
    .flush(rx_flush),
    .wr_en(fifo_wr),
    .wr_data(fifo_in),
    .rd_adv(fifo_adv),
    .rd_valid(fifo_valid),
    .rd_data(fifo_out)
  );

  // state register; lines load their idle levels at reset
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= '0;
      st_q.ctl_b <= `USFR_RST_B;
      st_q.ctl_c <= `USFR_RST_C;
      st_q.baud <= `USFR_RST_BAUD;
      st_q.txo <= 1'b1;
      st_q.in_sy <= 2'b11;
    end
    else
      st_q <= st_d;
  end

  // outputs straight from flops
  assign reg_rdata = st_q.rdata;
  assign serial_out_pin = st_q.txo;
  assign serial_out_oe = st_q.tx_on; // R11
  assign serial_in_own = st_q.ctl_b[`USFR_B_RX_EN]; // R12
  // interrupt levels; global gating is applied outside
  assign tx_empty_irq = ~st_q.hold_full &
    st_q.ctl_b[`USFR_B_TX_EMPTY_IE]; // R3 R24
  assign tx_done_irq = st_q.tx_done &
    st_q.ctl_b[`USFR_B_TX_DONE_IE]; // R8 R24
endmodule
`default_nettype wire

// >>> verif/usfr_assertions.sv
// Purpose: port-level checks of the serial block
// Assumes: register strobes one cycle long, one clock domain
// Notes: bound onto usfr_core from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "usfr_map.svh"
module usfr_chk
  import usfr_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_in_pin,
  input wire logic sync_clock_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic serial_in_own,
  input wire logic tx_empty_irq,
  input wire logic tx_done_irq_ack,
  input wire logic tx_done_irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // control b and status a writes, decoded once
  logic wr_b;
  logic wr_a;
  assign wr_b = reg_wr && reg_addr == `USFR_CONTROL_REG_B;
  assign wr_a = reg_wr && reg_addr == `USFR_STATUS_REG_A;
  a_empty_irq_off: assert property (
    wr_b && !reg_wdata[5] |-> ##[1:2] !tx_empty_irq)
    else $error("empty irq up without enable");
  a_done_ack_clr: assert property (
    tx_done_irq_ack |-> ##[1:2] !tx_done_irq)
    else $error("done irq survives ack");
  a_done_w1c: assert property (
    wr_a && reg_wdata[6] |-> ##[1:2] !tx_done_irq)
    else $error("done irq survives write one");
  a_rx_takeover: assert property (
    wr_b |-> ##2 serial_in_own == $past(reg_wdata[4], 2))
    else $error("input pin ownership wrong");
  a_tx_drive: assert property (
    wr_b && reg_wdata[3] |-> ##[1:2] serial_out_oe)
    else $error("enabled transmitter not driving");
  // a low line means a frame is in flight
  a_frame_hold: assert property (
    serial_out_oe && !serial_out_pin |=> serial_out_oe)
    else $error("output released mid frame");
  a_stop_release: assert property (
    $fell(serial_out_oe) |-> $past(serial_out_pin))
    else $error("output released on a low bit");
  a_done_idle: assert property (
    $rose(tx_done_irq) |-> !serial_out_oe || serial_out_pin)
    else $error("done raised before stop bit");
endmodule
`default_nettype wire

// >>> verif/usfr_peer.sv
// Purpose: remote sync serial peer, owns the transfer clock
// Assumes: one clock period per bit, lsb first
// Notes: clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module usfr_peer
(
  input wire logic line_in, // transmit wire, pulled high when released
  output logic xck, // transfer clock
  output logic line_out // receive wire, idles high
);
  initial
  begin
    xck = 1'b0;
    line_out = 1'b1;
  end
  // data moves mid low phase, stable across both edges
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      #32 line_out = f[i];
      #32 xck = 1'b1;
      #64 xck = 1'b0;
    end
    #32 line_out = 1'b1; // back to idle
  endtask
  // sample late in low phase so either launch edge is settled
  task automatic grab(output logic [11:0] f, input int n);
    int k;
    k = 0;
    f = '0;
    for (int i = 0; i < 40 && k < n; i++)
    begin
      #62;
      if (k > 0 || line_in === 1'b0)
      begin
        f[k] = line_in;
        k++;
      end
      #2 xck = 1'b1;
      #64 xck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/usfr_tb.sv
// Purpose: register-level test of the serial block with a sync peer
// Assumes: size code 3 is eight bits, 7 nine bits, 0 five bits
// Notes: every frame runs in sync mode, clocked by the peer
`timescale 1ns/1ps
`default_nettype none
`include "usfr_map.svh"
module tb;
  logic mclk, resetn, reg_wr, reg_rd, ack;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, v;
  logic [11:0] f;
  wire [7:0] reg_rdata;
  wire rxd, xck, txd, txd_oe, rx_own, e_irq, d_irq, line;
  int fails = 0;
  int checks = 0;
  // released output is pulled high on the wire
  assign line = txd_oe ? txd : 1'b1;
  usfr_core dut_u (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_in_pin(rxd), .sync_clock_pin(xck),
    .serial_out_pin(txd), .serial_out_oe(txd_oe),
    .serial_in_own(rx_own), .tx_empty_irq(e_irq),
    .tx_done_irq_ack(ack), .tx_done_irq(d_irq));
  usfr_peer peer_u (.line_in(line), .xck(xck), .line_out(rxd));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stands from the cycle after the strobe until the next read
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string s, input logic [11:0] e,
    input logic [11:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", s, e, g);
      fails++;
    end
  endtask
  // masked register read compare
  task automatic rc(input logic [2:0] a, input logic [7:0] m,
    input logic [7:0] e, input string s);
    logic [7:0] d;
    rd(a, d);
    chk(s, {4'h0, e}, {4'h0, d & m});
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    ack = 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rc(`USFR_STATUS_REG_A, 8'he4, 8'h20, "status");
    rc(`USFR_CONTROL_REG_C, 8'hff, 8'h03, "ctrl c");
    rd(3'h7, v); // unmapped place, only exercised
    // sync, eight bits, no parity; both directions on
    wr(`USFR_CONTROL_REG_C, 8'h43);
    wr(`USFR_CONTROL_REG_B, 8'h18);
    repeat (2) @(posedge mclk);
    chk("rx own", 12'h1, 12'(rx_own));
    peer_u.send({1'b0, 1'b1, 1'b1, 8'ha5, 1'b0}, 11);
    rc(`USFR_STATUS_REG_A, 8'h90, 8'h80, "status");
    rc(`USFR_DATA_BUFFER_REG, 8'hff, 8'ha5, "data");
    // nine bits, even parity, second frame with bad parity
    wr(`USFR_CONTROL_REG_C, 8'h67);
    peer_u.send({1'b1, ^9'h1a5, 9'h1a5, 1'b0}, 12);
    peer_u.send({1'b1, ~^9'h03c, 9'h03c, 1'b0}, 12);
    rc(`USFR_STATUS_REG_A, 8'h9c, 8'h80, "status 1");
    rc(`USFR_CONTROL_REG_B, 8'h02, 8'h02, "ninth 1");
    rc(`USFR_DATA_BUFFER_REG, 8'hff, 8'ha5, "data 1");
    rc(`USFR_STATUS_REG_A, 8'h84, 8'h84, "status 2");
    rc(`USFR_CONTROL_REG_B, 8'h02, 8'h00, "ninth 2");
    rc(`USFR_DATA_BUFFER_REG, 8'hff, 8'h3c, "data 2");
    rc(`USFR_STATUS_REG_A, 8'h80, 8'h00, "rx ready");
    // five bits: stop bit must not leak into the upper bits
    wr(`USFR_CONTROL_REG_C, 8'h40);
    peer_u.send({5'h1f, 1'b1, 5'h0a, 1'b0}, 7);
    rc(`USFR_DATA_BUFFER_REG, 8'hff, 8'h0a, "data 5");
    // odd parity, two characters queued, then disable at once
    wr(`USFR_CONTROL_REG_C, 8'h73);
    wr(`USFR_CONTROL_REG_B, 8'h58);
    wr(`USFR_DATA_BUFFER_REG, 8'h5a);
    wr(`USFR_DATA_BUFFER_REG, 8'h3c);
    rc(`USFR_STATUS_REG_A, 8'h20, 8'h00, "tx empty");
    wr(`USFR_CONTROL_REG_B, 8'h50);
    repeat (2) @(posedge mclk);
    chk("oe kept", 12'h1, 12'(txd_oe));
    peer_u.grab(f, 11);
    chk("frame 1", {1'b0, 1'b1, ~^8'h5a, 8'h5a, 1'b0}, f);
    peer_u.grab(f, 11);
    chk("frame 2", {1'b0, 1'b1, ~^8'h3c, 8'h3c, 1'b0}, f);
    for (int i = 0; i < 500 && d_irq !== 1'b1; i++)
      @(posedge mclk);
    chk("done irq", 12'h1, 12'(d_irq));
    repeat (2) @(posedge mclk);
    chk("oe off", 12'h0, 12'(txd_oe));
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("done ack", 12'h0, 12'(d_irq));
    rc(`USFR_STATUS_REG_A, 8'h60, 8'h20, "status");
    wr(`USFR_STATUS_REG_A, 8'h40);
    // empty irq follows its enable while the buffer is empty
    wr(`USFR_CONTROL_REG_B, 8'h20);
    repeat (2) @(posedge mclk);
    chk("empty irq", 12'h1, 12'(e_irq));
    wr(`USFR_CONTROL_REG_B, 8'h00);
    repeat (2) @(posedge mclk);
    chk("empty irq", 12'h0, 12'(e_irq));
    print_verdict();
  end
endmodule
bind usfr_core usfr_chk chk_u (.mclk, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .serial_in_pin, .sync_clock_pin,
  .serial_out_pin, .serial_out_oe, .serial_in_own, .tx_empty_irq,
  .tx_done_irq_ack, .tx_done_irq);
`default_nettype wire
